// ---- include/xlate_regs.svh ----
/*
  Register offsets, field positions and reset values of the translator control bank.
  Assumes a 32-bit Avalon-MM slave with byte addresses, one aligned word per register.
*/
`ifndef XLATE_REGS_SVH
`define XLATE_REGS_SVH

// byte offsets of the register words
`define SET0_OFS 5'h00
`define SET1_OFS 5'h04
`define CTRL_OFS 5'h08
`define STAT_OFS 5'h0c
`define EFF_OFS 5'h10

// configuration set word fields
`define SET_LOOP_LSB 0
`define SET_TYPE_BIT 8

// global control word fields
`define CTRL_MODE_LSB 0
`define CTRL_SEL_BIT 2
`define CTRL_SRC_BIT 3
`define CTRL_OEG_BIT 4
`define CTRL_RATE_LSB 5
`define CTRL_WIN_LSB 7
`define CTRL_DBL_BIT 9

// reset values: output gate open, sampler at crystal/4, window 2 us
`define CTRL_RST 32'h0000_0050
`define SET_LOOP_RST 7'h00
`define SET_TYPE_RST 1'b0

// status word fields
`define STAT_REF_BIT 0
`define STAT_XTAL_BIT 1
`define STAT_LOCK_BIT 2
`define STAT_FRZ_BIT 3

`endif

// ---- include/xlate_pkg.sv ----
/*
  Types shared by the translator control bank and its helper modules.
  Assumes xlate_regs.svh is compiled alongside for offsets and fields.
*/
`default_nettype none

package xlate_pkg;

  // effective loop mode after folding the two high-bandwidth codes together
  typedef enum logic [1:0] {MODE_LOW_BW, MODE_SYNTH, MODE_HIGH_BW} pll_mode_t;

  // one configuration set: loop setting and output type
  typedef struct packed {
    logic [6:0] loop;
    logic q_type;
  } set_t;

  // state of the control bank outside the two configuration sets and the synchronisers
  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic cfg_sel;
    logic cfg_src;
    logic oe_gate;
    logic [1:0] rate;
    logic [1:0] window;
    logic dbl;
    pll_mode_t pll_mode;
    logic active_set;
    logic q_enable;
    logic q_type;
    logic [3:0] gain;
    logic [1:0] lower_pump;
    logic lower_on;
    logic [1:0] filter;
    logic mod_order;
    logic mod_enable;
    logic [1:0] upper_pump;
    logic upper_reduce;
  } ctrl_state_t;

endpackage

`default_nettype wire

// ---- design/status_sync.sv ----
/*
  Two-flop synchroniser followed by an output register, W bits wide.
  Assumes raw inputs are asynchronous levels; output lags the input by three edges.
*/
`default_nettype none

module status_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] o;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = raw;
    st_next.s2 = st_reg.s1;
    st_next.o = st_reg.s2;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign synced = st_reg.o;

  // the flag follows its source exactly three edges later
  property mirror_p;
    @(posedge clk) disable iff (!rstn) ##3 1'b1 |-> synced == $past(raw, 3);
  endproperty
  flag_mirror_a: assert property (mirror_p) else $error("flag does not mirror source"); // RQ9

endmodule

`default_nettype wire

// ---- design/config_set.sv ----
/*
  Storage for one configuration set: loop setting and output type.
  Assumes the owner presents a full merged value with a one-cycle write strobe.
*/
`default_nettype none
`include "xlate_regs.svh"

module config_set (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write side
  input wire logic we,
  input wire logic [6:0] loop_in,
  input wire logic type_in,
  // stored set
  output logic [6:0] loop,
  output logic q_type
);

  xlate_pkg::set_t st_reg;
  xlate_pkg::set_t st_next;

  // hold unless written
  always_comb begin
    st_next = st_reg;
    if (we) begin
      st_next.loop = loop_in;
      st_next.q_type = type_in;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.loop <= `SET_LOOP_RST;
      st_reg.q_type <= `SET_TYPE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign loop = st_reg.loop;
  assign q_type = st_reg.q_type;

endmodule

`default_nettype wire

// ---- design/xlate_ctrl.sv ----
/*
  Global control and status bank of a frequency-translator clock device, with the
  per-set loop settings, behind an Avalon-MM slave with waitrequest.
  Assumes analog status levels and the two control pins arrive asynchronously and
  that the loop, divider and output circuits consume the registered outputs.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
//
// Function
// RQ1: mode 00 low-bandwidth, 01 synthesizer, 10 and 11 high-bandwidth.
// RQ2: source bit 0 takes active set from pin, 1 from register bit.
// RQ3: set-select bit picks set 0 or 1, ignored under pin control.
// RQ4: output enabled only when gate bit and enable pin are both high.
// RQ5: host writes zero into reserved bit positions.
// RQ6: low-bandwidth sampler rate is crystal divided by 16, 8, 4, 2.
// RQ7: edge window code selects 2, 4, 8 or 16 us; 00 recommended.
// RQ8: doubler bit doubles crystal frequency ahead of the phase detector.
// RQ9: reference fault flag reads 1 while input bad, mirrored on pin.
// RQ10: crystal fault flag reads 1 while crystal bad, mirrored on pin.
// RQ11: lock flag reads 1 when locked, mirrored on pin.
// RQ12: frozen flag reads 1 while oscillator frozen, mirrored on pin.
// RQ13: loop bits 6:3 are sampler gain in low-bandwidth, loop controls otherwise.
// RQ14: low-bandwidth loop bits 2:1 set lower pump; lower loop only there.
// RQ15: upper filter select applies outside low-bandwidth, else acts as 00.
// RQ16: modulator order bit selects second order at 0, third at 1.
// RQ17: modulator enable 0 keeps integer feedback, 1 enables fractional.
// RQ18: upper pump codes 00,01,10 valid; low-bandwidth acts as 00.
// RQ19: reduction bit cuts upper pump current by one third.
// RQ20: host programs pump 10, reduce 0, filter 11 for 4 MHz.
// RQ21: loop and output type exist per set; only active copy applies.
// RQ22: status flags are read-only; host writes leave them unchanged.
`default_nettype none
`include "xlate_regs.svh"

module xlate_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // device pins, asynchronous
  input wire logic config_pin,
  input wire logic oe_pin,
  // analog status levels, asynchronous
  input wire logic ref_bad_in,
  input wire logic crystal_bad_in,
  input wire logic locked_in,
  input wire logic frozen_in,
  // status pins
  output logic ref_fault_pin,
  output logic crystal_fault_pin,
  output logic pll_locked_pin,
  output logic frozen_tracking_pin,
  // global settings to the analog core
  output xlate_pkg::pll_mode_t pll_mode,
  output logic [1:0] sampler_rate,
  output logic [1:0] edge_window_width,
  output logic crystal_doubler,
  // active configuration set
  output logic active_set,
  output logic q_enable,
  output logic q_type,
  // decoded loop setting
  output logic [3:0] sampler_gain,
  output logic [1:0] lower_pump_current,
  output logic lower_loop_on,
  output logic [1:0] upper_loop_filter_sel,
  output logic modulator_order,
  output logic modulator_enable,
  output logic [1:0] upper_pump_current,
  output logic upper_pump_reduce
);

  xlate_pkg::ctrl_state_t st_reg;
  xlate_pkg::ctrl_state_t st_next;

  logic [3:0] flags;
  logic [1:0] pins_s;
  logic [6:0] loop0;
  logic [6:0] loop1;
  logic type0;
  logic type1;
  logic we0;
  logic we1;
  logic [31:0] set_merged;
  logic bus_hit;
  logic commit;
  logic sel;
  logic [6:0] loop_act;
  logic [31:0] ctrl_word;
  logic [31:0] rd_mux;

  // merge write data into an old word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return (old & ~m) | (wd & m);
  endfunction

  // status flags pass a synchroniser; the pins are its flopped outputs
  status_sync #(
    .W(4)
  ) u_stat (
    .clk(clk),
    .rstn(rstn),
    .raw({frozen_in, locked_in, crystal_bad_in, ref_bad_in}),
    .synced(flags)
  );

  // config and enable pins are asynchronous too
  status_sync #(
    .W(2)
  ) u_pins (
    .clk(clk),
    .rstn(rstn),
    .raw({oe_pin, config_pin}),
    .synced(pins_s)
  );

  // the two configuration sets
  config_set u_set0 (
    .clk(clk),
    .rstn(rstn),
    .we(we0),
    .loop_in(set_merged[`SET_LOOP_LSB +: 7]),
    .type_in(set_merged[`SET_TYPE_BIT]),
    .loop(loop0),
    .q_type(type0)
  );

  config_set u_set1 (
    .clk(clk),
    .rstn(rstn),
    .we(we1),
    .loop_in(set_merged[`SET_LOOP_LSB +: 7]),
    .type_in(set_merged[`SET_TYPE_BIT]),
    .loop(loop1),
    .q_type(type1)
  );

  // bus timing: request seen with waitrequest high, answered one cycle later
  assign bus_hit = (read | write) & st_reg.wait_req;
  assign commit = write & ~st_reg.wait_req;

  // active set follows the pin unless register control is chosen
  assign sel = st_reg.cfg_src ? st_reg.cfg_sel : pins_s[0]; // RQ2 RQ3
  assign loop_act = sel ? loop1 : loop0; // RQ21

  // current control word, reserved positions read as zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`CTRL_MODE_LSB +: 2] = st_reg.mode;
    ctrl_word[`CTRL_SEL_BIT] = st_reg.cfg_sel;
    ctrl_word[`CTRL_SRC_BIT] = st_reg.cfg_src;
    ctrl_word[`CTRL_OEG_BIT] = st_reg.oe_gate;
    ctrl_word[`CTRL_RATE_LSB +: 2] = st_reg.rate;
    ctrl_word[`CTRL_WIN_LSB +: 2] = st_reg.window;
    ctrl_word[`CTRL_DBL_BIT] = st_reg.dbl;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (address)
      `SET0_OFS: rd_mux = {23'h0, type0, 1'b0, loop0};
      `SET1_OFS: rd_mux = {23'h0, type1, 1'b0, loop1};
      `CTRL_OFS: rd_mux = ctrl_word;
      `STAT_OFS: rd_mux = {28'h0, flags}; // RQ9 RQ10 RQ11 RQ12
      `EFF_OFS: rd_mux = {28'h0, st_reg.q_enable, st_reg.active_set, st_reg.pll_mode};
      default: rd_mux = '0;
    endcase
  end

  // set writes merge into the addressed set's present word
  assign we0 = commit & (address == `SET0_OFS);
  assign we1 = commit & (address == `SET1_OFS);
  assign set_merged = merge(address == `SET1_OFS ? {23'h0, type1, 1'b0, loop1}
                                                 : {23'h0, type0, 1'b0, loop0},
                            writedata, byteenable);

  // next state: bus answer, control writes and decoded outputs
  always_comb begin
    logic [31:0] cw;
    cw = merge(ctrl_word, writedata, byteenable);
    st_next = st_reg;
    st_next.wait_req = ~bus_hit;
    if (bus_hit && read) begin
      st_next.rdata = rd_mux;
    end
    // status offset has no storage, so writes there fall away
    if (commit && address == `CTRL_OFS) begin // RQ22
      st_next.mode = cw[`CTRL_MODE_LSB +: 2];
      st_next.cfg_sel = cw[`CTRL_SEL_BIT];
      st_next.cfg_src = cw[`CTRL_SRC_BIT];
      st_next.oe_gate = cw[`CTRL_OEG_BIT];
      st_next.rate = cw[`CTRL_RATE_LSB +: 2]; // RQ6
      st_next.window = cw[`CTRL_WIN_LSB +: 2]; // RQ7
      st_next.dbl = cw[`CTRL_DBL_BIT]; // RQ8
    end
    unique case (st_reg.mode)
      2'b00: st_next.pll_mode = xlate_pkg::MODE_LOW_BW; // RQ1
      2'b01: st_next.pll_mode = xlate_pkg::MODE_SYNTH;
      2'b10, 2'b11: st_next.pll_mode = xlate_pkg::MODE_HIGH_BW;
    endcase
    st_next.active_set = sel;
    st_next.q_type = sel ? type1 : type0; // RQ21
    st_next.q_enable = st_reg.oe_gate & pins_s[1]; // RQ4
    st_next.upper_reduce = loop_act[0]; // RQ19
    // the same seven bits mean different things per mode
    if (st_reg.mode == 2'b00) begin
      st_next.gain = loop_act[6:3]; // RQ13
      st_next.lower_pump = loop_act[2:1]; // RQ14
      st_next.lower_on = 1'b1;
      st_next.filter = 2'b00; // RQ15
      st_next.mod_order = 1'b0;
      st_next.mod_enable = 1'b0;
      st_next.upper_pump = 2'b00; // RQ18
    end else begin
      st_next.gain = 4'h0;
      st_next.lower_pump = 2'b00;
      st_next.lower_on = 1'b0; // RQ14
      st_next.filter = loop_act[6:5]; // RQ15
      st_next.mod_order = loop_act[4]; // RQ16
      st_next.mod_enable = loop_act[3]; // RQ17
      st_next.upper_pump = loop_act[2:1]; // RQ18
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.wait_req <= 1'b1;
      st_reg.pll_mode <= xlate_pkg::MODE_LOW_BW;
      st_reg.oe_gate <= 1'(`CTRL_RST >> `CTRL_OEG_BIT);
      st_reg.rate <= 2'(`CTRL_RST >> `CTRL_RATE_LSB);
      st_reg.lower_on <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output is a flop of the state or of a helper's flop
  assign readdata = st_reg.rdata;
  assign waitrequest = st_reg.wait_req;
  assign ref_fault_pin = flags[`STAT_REF_BIT]; // RQ9
  assign crystal_fault_pin = flags[`STAT_XTAL_BIT]; // RQ10
  assign pll_locked_pin = flags[`STAT_LOCK_BIT]; // RQ11
  assign frozen_tracking_pin = flags[`STAT_FRZ_BIT]; // RQ12
  assign pll_mode = st_reg.pll_mode;
  assign sampler_rate = st_reg.rate;
  assign edge_window_width = st_reg.window;
  assign crystal_doubler = st_reg.dbl;
  assign active_set = st_reg.active_set;
  assign q_enable = st_reg.q_enable;
  assign q_type = st_reg.q_type;
  assign sampler_gain = st_reg.gain;
  assign lower_pump_current = st_reg.lower_pump;
  assign lower_loop_on = st_reg.lower_on;
  assign upper_loop_filter_sel = st_reg.filter;
  assign modulator_order = st_reg.mod_order;
  assign modulator_enable = st_reg.mod_enable;
  assign upper_pump_current = st_reg.upper_pump;
  assign upper_pump_reduce = st_reg.upper_reduce;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // bus handshake: one wait cycle, one answer cycle, then waiting again
  sequence req_seen_s;
    (read | write) && waitrequest;
  endsequence
  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence
  bus_handshake_a: assert property (req_seen_s |=> answer_s)
    else $error("waitrequest handshake broken");

  // read data taken at the answer edge match the addressed status word
  read_status_a: assert property (read && waitrequest && address == `STAT_OFS // RQ22
    |=> readdata == {28'h0, $past(flags)}) else $error("status read wrong");

  mode_map_a: assert property (##1 1'b1 |-> pll_mode == ($past(st_reg.mode) == 2'b00 ? // RQ1
    xlate_pkg::MODE_LOW_BW : $past(st_reg.mode) == 2'b01 ? xlate_pkg::MODE_SYNTH :
    xlate_pkg::MODE_HIGH_BW)) else $error("mode decode wrong");

  set_source_a: assert property (##1 1'b1 |-> active_set == ($past(st_reg.cfg_src) ? // RQ2
    $past(st_reg.cfg_sel) : $past(pins_s[0]))) else $error("active set wrong");

  out_gate_a: assert property (q_enable |-> $past(st_reg.oe_gate) && $past(pins_s[1])) // RQ4
    else $error("output enabled without both enables");

  // a control write reaches the sampler rate at the answer edge
  ctrl_write_a: assert property (write && !waitrequest && address == `CTRL_OFS && // RQ6
    byteenable[0] |=> sampler_rate == $past(writedata[`CTRL_RATE_LSB +: 2]))
    else $error("sampler rate not written");

  // a control write with both low lanes enabled, taken at the answer edge
  sequence ctrl_commit_s;
    write && !waitrequest && address == `CTRL_OFS && byteenable[1:0] == 2'b11;
  endsequence
  window_write_a: assert property (ctrl_commit_s |=> // RQ7
    edge_window_width == $past(writedata[`CTRL_WIN_LSB +: 2]))
    else $error("edge window not written");
  doubler_write_a: assert property (ctrl_commit_s |=> // RQ8
    crystal_doubler == $past(writedata[`CTRL_DBL_BIT])) else $error("doubler not written");

  // a full-word write to set 0 lands in set 0's storage at the answer edge
  sequence set0_commit_s;
    write && !waitrequest && address == `SET0_OFS && byteenable == 4'hf;
  endsequence
  set_store_a: assert property (set0_commit_s |=> // RQ21
    loop0 == $past(writedata[6:0]) && type0 == $past(writedata[`SET_TYPE_BIT]))
    else $error("set word not stored");

  low_bw_fold_a: assert property (##1 $past(st_reg.mode) == 2'b00 |-> // RQ13
    upper_loop_filter_sel == 2'b00 && upper_pump_current == 2'b00 && lower_loop_on &&
    sampler_gain == $past(loop_act[6:3])) else $error("low-bandwidth decode wrong");

  lower_pump_a: assert property (##1 $past(st_reg.mode) == 2'b00 |-> // RQ14
    lower_pump_current == $past(loop_act[2:1]) && !modulator_order && !modulator_enable)
    else $error("lower pump decode wrong");

  modulator_map_a: assert property (##1 $past(st_reg.mode) != 2'b00 |-> // RQ16
    modulator_order == $past(loop_act[4]) && modulator_enable == $past(loop_act[3]) &&
    !lower_loop_on) else $error("modulator decode wrong");

  // outside low-bandwidth the upper loop takes the stored fields and the sampler is idle
  upper_loop_a: assert property (##1 $past(st_reg.mode) != 2'b00 |-> // RQ15
    upper_loop_filter_sel == $past(loop_act[6:5]) &&
    upper_pump_current == $past(loop_act[2:1]) && sampler_gain == 4'h0)
    else $error("upper loop decode wrong");

  active_copy_a: assert property (##1 1'b1 |-> q_type == ($past(sel) ? $past(type1) : // RQ21
    $past(type0))) else $error("inactive set applied");

  reduce_map_a: assert property (##1 1'b1 |-> upper_pump_reduce == $past(loop_act[0])) // RQ19
    else $error("pump reduction wrong");

endmodule

`default_nettype wire

// ---- testbench/host_model.sv ----
/*
  Host side of the control bank: an Avalon-MM master with word write and read tasks.
  Assumes one clock shared with the slave, which answers by dropping waitrequest.
*/
`default_nettype none
`include "xlate_regs.svh"

module host_model (
  // clock
  input wire logic clk,
  // avalon-mm master
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end

  // implemented bits of each word; anything else is reserved and always sent as zero
  function automatic logic [31:0] used_bits(input logic [4:0] a);
    case (a)
      `SET0_OFS, `SET1_OFS: return 32'h0000_017f;
      `CTRL_OFS: return 32'h0000_03ff;
      `STAT_OFS, `EFF_OFS: return 32'h0000_000f;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // request held until waitrequest is sampled low, released at that same edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d & used_bits(a);
    byteenable <= 4'hf;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  // read data taken at the edge where waitrequest is low
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    byteenable <= 4'hf;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench of the translator control bank: bus accesses, pins and status levels.
  Assumes host_model drives the register bus and the pins settle within four edges.
*/
`default_nettype none
`include "xlate_regs.svh"
`define CHK(nm, e, g) check_val(nm, e, g)

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset, pins and status levels
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic config_pin = 1'b0;
  logic oe_pin = 1'b0;
  logic [3:0] stat_in = 4'h0;
  wire logic [3:0] stat_pin;
  // register bus
  logic [4:0] address;
  logic read, write, waitrequest;
  logic [31:0] writedata, readdata, rdv;
  logic [3:0] byteenable;
  // outputs to the analog core
  xlate_pkg::pll_mode_t pll_mode;
  logic [1:0] sampler_rate, edge_window_width, lower_pump_current;
  logic [1:0] upper_loop_filter_sel, upper_pump_current;
  logic crystal_doubler, active_set, q_enable, q_type, lower_loop_on;
  logic modulator_order, modulator_enable, upper_pump_reduce;
  logic [3:0] sampler_gain;
  logic [3:0] pats [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  host_model u_host (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  xlate_ctrl u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .config_pin(config_pin), .oe_pin(oe_pin),
    .ref_bad_in(stat_in[0]), .crystal_bad_in(stat_in[1]), .locked_in(stat_in[2]),
    .frozen_in(stat_in[3]), .ref_fault_pin(stat_pin[0]), .crystal_fault_pin(stat_pin[1]),
    .pll_locked_pin(stat_pin[2]), .frozen_tracking_pin(stat_pin[3]), .pll_mode(pll_mode),
    .sampler_rate(sampler_rate), .edge_window_width(edge_window_width),
    .crystal_doubler(crystal_doubler), .active_set(active_set), .q_enable(q_enable),
    .q_type(q_type), .sampler_gain(sampler_gain), .lower_pump_current(lower_pump_current),
    .lower_loop_on(lower_loop_on), .upper_loop_filter_sel(upper_loop_filter_sel),
    .modulator_order(modulator_order), .modulator_enable(modulator_enable),
    .upper_pump_current(upper_pump_current), .upper_pump_reduce(upper_pump_reduce));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // wait n edges, then sample at the falling edge where everything has settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic s, input logic src,
      input logic g, input logic [1:0] r, input logic [1:0] w, input logic d);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[`CTRL_MODE_LSB +: 2] = m;
    c[`CTRL_SEL_BIT] = s;
    c[`CTRL_SRC_BIT] = src;
    c[`CTRL_OEG_BIT] = g;
    c[`CTRL_RATE_LSB +: 2] = r;
    c[`CTRL_WIN_LSB +: 2] = w;
    c[`CTRL_DBL_BIT] = d;
    return c;
  endfunction

  // loop setting meaning depends on whether the loop runs in low-bandwidth mode
  task automatic check_decode(input logic [6:0] lp, input logic low);
    `CHK("gain", low ? lp[6:3] : 4'h0, sampler_gain);
    `CHK("lower_pump", low ? lp[2:1] : 2'h0, lower_pump_current);
    `CHK("lower_on", low, lower_loop_on);
    `CHK("filter", low ? 2'h0 : lp[6:5], upper_loop_filter_sel);
    `CHK("order", low ? 1'b0 : lp[4], modulator_order);
    `CHK("mod_en", low ? 1'b0 : lp[3], modulator_enable);
    `CHK("upper_pump", low ? 2'h0 : lp[2:1], upper_pump_current);
    `CHK("reduce", lp[0], upper_pump_reduce);
  endtask

  // hang guard: the sequence needs a few hundred cycles at most
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    @(negedge clk);
    `CHK("wait_in_reset", 1'b1, waitrequest);
    `CHK("rate_in_reset", 2'h2, sampler_rate);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    u_host.rd(`CTRL_OFS, rdv);
    `CHK("ctrl_reset", `CTRL_RST, rdv);
    u_host.rd(5'h14, rdv);
    `CHK("unmapped", 32'h0, rdv);
    // pin control: the select bit is set opposite to the pin and must be ignored
    u_host.wr(`SET0_OFS, 32'h0000_005a);
    u_host.wr(`SET1_OFS, 32'h0000_0127);
    for (int p = 0; p < 2; p++) begin
      u_host.wr(`CTRL_OFS, ctrl(2'h0, ~p[0], 1'b0, 1'b1, 2'h2, 2'h0, 1'b0));
      config_pin <= p[0];
      tick(4);
      `CHK("set_by_pin", p, active_set);
      `CHK("type_by_pin", p, q_type);
      check_decode(p[0] ? 7'h27 : 7'h5a, 1'b1);
    end
    // register control with the pin held high
    for (int s = 0; s < 2; s++) begin
      u_host.wr(`CTRL_OFS, ctrl(2'h0, s[0], 1'b1, 1'b1, 2'h2, 2'h0, 1'b0));
      tick(1);
      `CHK("set_by_reg", s, active_set);
      `CHK("type_by_reg", s, q_type);
    end
    // every mode code, active set holding the 4 MHz loop setting
    u_host.wr(`SET1_OFS, 32'h0000_017c);
    for (int m = 0; m < 4; m++) begin
      u_host.wr(`CTRL_OFS, ctrl(2'(m), 1'b1, 1'b1, 1'b1, 2'h2, 2'h0, 1'b0));
      tick(1);
      `CHK("pll_mode", m == 0 ? xlate_pkg::MODE_LOW_BW : (m == 1 ? xlate_pkg::MODE_SYNTH :
        xlate_pkg::MODE_HIGH_BW), pll_mode);
      u_host.rd(`EFF_OFS, rdv);
      `CHK("eff_mode", m == 3 ? 2 : m, rdv[1:0]);
      check_decode(7'h7c, m == 0);
    end
    // every sampler rate, window and doubler code
    for (int k = 0; k < 4; k++) begin
      u_host.wr(`CTRL_OFS, ctrl(2'h0, 1'b0, 1'b0, 1'b1, 2'(k), 2'(3 - k), k[0]));
      tick(1);
      `CHK("rate", k, sampler_rate);
      `CHK("window", 3 - k, edge_window_width);
      `CHK("doubler", k[0], crystal_doubler);
    end
    // output enable needs both gate bit and pin
    for (int i = 0; i < 4; i++) begin
      u_host.wr(`CTRL_OFS, ctrl(2'h0, 1'b0, 1'b0, i[1], 2'h2, 2'h0, 1'b0));
      oe_pin <= i[0];
      tick(4);
      `CHK("q_enable", i[1] & i[0], q_enable);
      u_host.rd(`EFF_OFS, rdv);
      `CHK("eff_enable", i[1] & i[0], rdv[3]);
    end
    // live status levels on pins and word, ending with all cleared
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      stat_in <= pats[j];
      tick(4);
      `CHK("status_pins", pats[j], stat_pin);
      // the inverse pattern written to the status word must not reach the flags
      u_host.wr(`STAT_OFS, {28'h0, ~pats[j]});
      u_host.rd(`STAT_OFS, rdv);
      `CHK("status_word", pats[j], rdv);
    end
    u_host.wr(`STAT_OFS, 32'h0000_000f);
    u_host.rd(`STAT_OFS, rdv);
    `CHK("status_ro", 32'h0, rdv);
    complete_run();
  end
endmodule

`default_nettype wire
